/* File: hdl/irqdc_top.sv */
// Purpose: Interrupt request flags, priority levels and DMA request control
// Assumes: All inputs synchronous to aclk; AXI4-Lite slave, 8-bit registers
// Notes:   Contract list below; status/mask pair drives the irq output
//
// Contract
// - Read-only request flag, 3-bit level, zero reset
// - Writing a vector to clear register clears flag
// - Four software DMA request bits, reset zero
// - Four burst bits select burst mode per channel
// - Per input edge or level detection bit
// - Edge polarity bit, rising or falling
// - Optional non-maskable start on rising edge
// - Timer overflow has its own flag and level
`timescale 1ns/100ps
module irqdc_top #(
    parameter logic [5:0] VEC_BASE = 6'h0A       // Vector of slot 0, arbitrary
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write
    input  wire logic [11:0]           awaddr,
    input  wire logic [2:0]            awprot,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // AXI4-Lite read
    input  wire logic [11:0]           araddr,
    input  wire logic [2:0]            arprot,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // Request sources
    input  wire logic [23:0]           src_evt,
    input  wire logic [5:0]            ext_in,
    input  wire logic                  nmi_in,
    // CPU side
    output irqdc_pkg::irqdc_cpu_req_t  cpu_req,
    input  wire logic                  cpu_ack,
    output logic                       nmi_out,
    // DMA side
    output irqdc_pkg::irqdc_dma_t      dma,
    input  wire logic [3:0]            dma_ack,
    // Interrupt
    output logic                       irq
);
    localparam int NSRC = irqdc_pkg::NSRC;

    // Vector owned by a nibble slot
    function automatic logic [5:0] vec_of(input int n);
        vec_of = VEC_BASE + 6'(n);
    endfunction : vec_of

    // Control slot of a register index, NSLOT when none
    function automatic int ctl_slot(input logic [7:0] idx);
        ctl_slot = irqdc_pkg::NSLOT;
        for (int s = 0; s < irqdc_pkg::NSLOT; s++) begin
            if (irqdc_pkg::CTL_IDX[s] == idx) ctl_slot = s;
        end
    endfunction : ctl_slot

    // Bus state
    logic        aw_have_r, aw_have_nxt;         // Write address held
    logic [11:0] aw_addr_r, aw_addr_nxt;
    logic        w_have_r,  w_have_nxt;          // Write data held
    logic [7:0]  w_data_r,  w_data_nxt;
    logic        w_lane_r,  w_lane_nxt;          // Low byte lane enabled
    logic        awready_r, awready_nxt;
    logic        wready_r,  wready_nxt;
    logic        bvalid_r,  bvalid_nxt;
    logic [1:0]  bresp_r,   bresp_nxt;
    logic        arready_r, arready_nxt;
    logic        rvalid_r,  rvalid_nxt;
    logic [1:0]  rresp_r,   rresp_nxt;
    logic [31:0] rdata_r,   rdata_nxt;
    // Core state
    logic [NSRC-1:0]       flag_r, flag_nxt;     // Pending request flags
    logic [NSRC-1:0][2:0]  lvl_r,  lvl_nxt;      // Priority levels
    logic [3:0][5:0]       dmav_r, dmav_nxt;     // DMA start vectors
    logic [3:0]            soft_r, soft_nxt;     // Software DMA requests
    logic [3:0]            burst_r, burst_nxt;   // Burst selects
    logic [5:0]            le_r,   le_nxt;       // Level detection select
    logic [5:0]            pol_r,  pol_nxt;      // Falling edge select
    logic                  nrise_r, nrise_nxt;   // Non-maskable rising enable
    logic [5:0]            ext_prev_r;           // Last input levels
    logic                  nmi_prev_r;
    logic [2:0]            stat_r, stat_nxt;     // Sticky events
    logic [2:0]            mask_r, mask_nxt;
    logic                  irq_r,  irq_nxt;
    logic                  nmi_r,  nmi_nxt;
    irqdc_pkg::irqdc_cpu_req_t cpu_r, cpu_nxt;
    irqdc_pkg::irqdc_dma_t     dma_r, dma_nxt;
    // Decoded strobes
    logic        wr_go;                          // Write performed this cycle
    logic [7:0]  widx;                           // Index of the held write
    logic        wr_en;                          // Write reaches a register

    assign wr_go = aw_have_r && w_have_r && !bvalid_r;
    assign widx  = aw_addr_r[9:2];
    assign wr_en = wr_go && w_lane_r && aw_addr_r[11:10] == 2'h0;

    // Bus handshakes: address and data taken in either order
    always_comb begin
        int          s;
        logic [7:0]  ridx;
        logic        hit;
        s = 0;
        ridx = araddr[9:2];
        hit = 1'b0;
        aw_have_nxt = (aw_have_r && !wr_go) || (awvalid && awready_r);
        aw_addr_nxt = (awvalid && awready_r) ? awaddr : aw_addr_r;
        w_have_nxt  = (w_have_r && !wr_go) || (wvalid && wready_r);
        w_data_nxt  = (wvalid && wready_r) ? wdata[7:0] : w_data_r;
        w_lane_nxt  = (wvalid && wready_r) ? wstrb[0] : w_lane_r;
        awready_nxt = !aw_have_nxt;
        wready_nxt  = !w_have_nxt;
        bvalid_nxt  = wr_go || (bvalid_r && !bready);
        bresp_nxt   = bresp_r;
        // Unmapped write address answers SLVERR
        if (wr_go) begin
            s = ctl_slot(widx);
            hit = aw_addr_r[11:10] == 2'h0 && (s < irqdc_pkg::NSLOT
                  || (widx >= irqdc_pkg::IDX_DMAV0 && widx <= irqdc_pkg::IDX_DMAV3)
                  || widx == irqdc_pkg::IDX_CLR || widx == irqdc_pkg::IDX_DMA_SOFT_REQUEST
                  || widx == irqdc_pkg::IDX_DMA_BURST_SELECT || widx == irqdc_pkg::IDX_MODE_LO
                  || widx == irqdc_pkg::IDX_MODE_HI || widx == irqdc_pkg::IDX_STAT
                  || widx == irqdc_pkg::IDX_MASK);
            bresp_nxt = hit ? irqdc_pkg::RESP_OK : irqdc_pkg::RESP_SLVERR;
        end
        // Read mux; write-only registers read as zero
        rvalid_nxt  = (arvalid && arready_r) || (rvalid_r && !rready);
        arready_nxt = !rvalid_nxt;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        if (arvalid && arready_r) begin
            rdata_nxt = 32'h0000_0000;
            rresp_nxt = irqdc_pkg::RESP_OK;
            s = ctl_slot(ridx);
            if (araddr[11:10] != 2'h0) begin
                rresp_nxt = irqdc_pkg::RESP_SLVERR;
            end else if (s < irqdc_pkg::NSLOT) begin
                rdata_nxt[7:0] = {flag_r[2*s+1], lvl_r[2*s+1], flag_r[2*s], lvl_r[2*s]};
            end else if (ridx >= irqdc_pkg::IDX_DMAV0 && ridx <= irqdc_pkg::IDX_DMAV3) begin
                rdata_nxt[5:0] = dmav_r[ridx[1:0]];
            end else if (ridx == irqdc_pkg::IDX_DMA_SOFT_REQUEST) begin
                rdata_nxt[3:0] = soft_r;
            end else if (ridx == irqdc_pkg::IDX_DMA_BURST_SELECT) begin
                rdata_nxt[3:0] = burst_r;
            end else if (ridx == irqdc_pkg::IDX_STAT) begin
                rdata_nxt[2:0] = stat_r;
            end else if (ridx == irqdc_pkg::IDX_MASK) begin
                rdata_nxt[2:0] = mask_r;
            end else if (ridx != irqdc_pkg::IDX_CLR && ridx != irqdc_pkg::IDX_MODE_LO
                         && ridx != irqdc_pkg::IDX_MODE_HI) begin
                rresp_nxt = irqdc_pkg::RESP_SLVERR;
            end
        end
    end

    // Bus registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_have_r  <= 1'b0;
            w_data_r  <= irqdc_pkg::RST_BYTE;
            w_lane_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= irqdc_pkg::RESP_OK;
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rresp_r   <= irqdc_pkg::RESP_OK;
            rdata_r   <= 32'h0000_0000;
        end else begin
            aw_have_r <= aw_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_have_r  <= w_have_nxt;
            w_data_r  <= w_data_nxt;
            w_lane_r  <= w_lane_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // Core: detection, flags, arbitration and DMA requests
    always_comb begin
        logic [NSRC-1:0] set, clr, own;
        logic            clr_hit, nrise, nfall;
        int              s;
        set = '0;
        clr = '0;
        own = '0;
        clr_hit = 1'b0;
        nrise = !nmi_prev_r && nmi_in;
        nfall = nmi_prev_r && !nmi_in;
        s = ctl_slot(widx);
        lvl_nxt = lvl_r;
        dmav_nxt = dmav_r;
        soft_nxt = soft_r;
        burst_nxt = burst_r;
        le_nxt = le_r;
        pol_nxt = pol_r;
        nrise_nxt = nrise_r;
        mask_nxt = mask_r;
        stat_nxt = stat_r;
        // Peripheral pulses; unused slots never set
        set = src_evt & irqdc_pkg::SRC_USED;
        // External inputs: level or selected edge
        for (int k = 0; k < irqdc_pkg::NEXT; k++) begin
            if (le_r[k]) begin
                set[irqdc_pkg::EXT_NIB[k]] = ext_in[k];
            end else if (pol_r[k]) begin
                set[irqdc_pkg::EXT_NIB[k]] = ext_prev_r[k] && !ext_in[k];
            end else begin
                set[irqdc_pkg::EXT_NIB[k]] = !ext_prev_r[k] && ext_in[k];
            end
        end
        // Register writes; flag bits of control registers are not writable
        if (wr_en) begin
            if (s < irqdc_pkg::NSLOT) begin
                lvl_nxt[2*s]   = w_data_r[2:0];
                lvl_nxt[2*s+1] = w_data_r[6:4];
            end
            if (widx >= irqdc_pkg::IDX_DMAV0 && widx <= irqdc_pkg::IDX_DMAV3) begin
                dmav_nxt[widx[1:0]] = w_data_r[5:0];
            end
            if (widx == irqdc_pkg::IDX_DMA_BURST_SELECT) begin
                burst_nxt = w_data_r[3:0];
            end
            if (widx == irqdc_pkg::IDX_MODE_LO || widx == irqdc_pkg::IDX_MODE_HI) begin
                for (int k = 0; k < 3; k++) begin
                    le_nxt[k + (widx[0] ? 3 : 0)]  = w_data_r[irqdc_pkg::LE_POS + 2*k];
                    pol_nxt[k + (widx[0] ? 3 : 0)] = w_data_r[irqdc_pkg::EDGE_POS + 2*k];
                end
                if (!widx[0]) nrise_nxt = w_data_r[irqdc_pkg::NMI_POS];
            end
            if (widx == irqdc_pkg::IDX_MASK) mask_nxt = w_data_r[2:0];
            // Clear vector: drop the flag that owns it
            if (widx == irqdc_pkg::IDX_CLR) begin
                for (int n = 0; n < NSRC; n++) begin
                    if (irqdc_pkg::SRC_USED[n] && w_data_r[5:0] == vec_of(n)) begin
                        clr[n] = 1'b1;
                        clr_hit = 1'b1;
                    end
                end
            end
        end
        // Sources claimed by a DMA channel are cleared by its acknowledge
        for (int c = 0; c < irqdc_pkg::NDMA; c++) begin
            for (int n = 0; n < NSRC; n++) begin
                if (dmav_r[c] != 6'h00 && dmav_r[c] == vec_of(n)) begin
                    own[n] = 1'b1;
                    if (dma_ack[c]) clr[n] = 1'b1;
                end
            end
        end
        // CPU acknowledge clears the vector it was offered
        if (cpu_ack && cpu_r.valid) begin
            for (int n = 0; n < NSRC; n++) begin
                if (cpu_r.vector == vec_of(n)) clr[n] = 1'b1;
            end
        end
        // A new event wins over any clear in the same cycle
        flag_nxt = (flag_r & ~clr) | set;
        // Software requests: acknowledge clears, a written one wins
        soft_nxt = soft_r & ~dma_ack;
        if (wr_en && widx == irqdc_pkg::IDX_DMA_SOFT_REQUEST) begin
            soft_nxt = soft_nxt | w_data_r[3:0];
        end
        // DMA outputs: software bit or the claimed source pending
        for (int c = 0; c < irqdc_pkg::NDMA; c++) begin
            dma_nxt.req[c] = soft_r[c];
            for (int n = 0; n < NSRC; n++) begin
                if (dmav_r[c] != 6'h00 && dmav_r[c] == vec_of(n) && flag_r[n]) begin
                    dma_nxt.req[c] = 1'b1;
                end
            end
        end
        dma_nxt.burst = burst_r;
        // Highest level wins, lowest slot on a tie; level zero is masked
        cpu_nxt = '0;
        for (int n = 0; n < NSRC; n++) begin
            if (flag_r[n] && !own[n] && lvl_r[n] != 3'h0 && lvl_r[n] > cpu_nxt.level) begin
                cpu_nxt.valid  = 1'b1;
                cpu_nxt.level  = lvl_r[n];
                cpu_nxt.vector = vec_of(n);
            end
        end
        // Non-maskable: falling edge always, rising when enabled
        nmi_nxt = nfall || (nrise && nrise_r);
        // Sticky events; write one to clear, a new event wins
        if (wr_en && widx == irqdc_pkg::IDX_STAT) stat_nxt = stat_r & ~w_data_r[2:0];
        if (nmi_nxt) stat_nxt[irqdc_pkg::ST_NMI] = 1'b1;
        if (wr_en && widx == irqdc_pkg::IDX_CLR && !clr_hit) begin
            stat_nxt[irqdc_pkg::ST_BADCLR] = 1'b1;
        end
        if (wr_en && widx == irqdc_pkg::IDX_DMA_SOFT_REQUEST && w_data_r[3:0] != 4'h0) begin
            stat_nxt[irqdc_pkg::ST_SOFT] = 1'b1;
        end
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    // Core registers; input history is plain sampling of synchronous pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_r     <= '0;
            lvl_r      <= '0;
            dmav_r     <= '0;
            soft_r     <= 4'h0;
            burst_r    <= 4'h0;
            le_r       <= 6'h00;
            pol_r      <= 6'h00;
            nrise_r    <= 1'b0;
            ext_prev_r <= 6'h00;
            nmi_prev_r <= 1'b0;
            stat_r     <= 3'h0;
            mask_r     <= 3'h0;
            irq_r      <= 1'b0;
            nmi_r      <= 1'b0;
            cpu_r      <= '0;
            dma_r      <= '0;
        end else begin
            flag_r     <= flag_nxt;
            lvl_r      <= lvl_nxt;
            dmav_r     <= dmav_nxt;
            soft_r     <= soft_nxt;
            burst_r    <= burst_nxt;
            le_r       <= le_nxt;
            pol_r      <= pol_nxt;
            nrise_r    <= nrise_nxt;
            ext_prev_r <= ext_in;
            nmi_prev_r <= nmi_in;
            stat_r     <= stat_nxt;
            mask_r     <= mask_nxt;
            irq_r      <= irq_nxt;
            nmi_r      <= nmi_nxt;
            cpu_r      <= cpu_nxt;
            dma_r      <= dma_nxt;
        end
    end

    // Outputs straight from flops
    assign awready = awready_r;
    assign wready  = wready_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign arready = arready_r;
    assign rvalid  = rvalid_r;
    assign rresp   = rresp_r;
    assign rdata   = rdata_r;
    assign cpu_req = cpu_r;
    assign dma     = dma_r;
    assign nmi_out = nmi_r;
    assign irq     = irq_r;

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence dma_soft_request_wr_s;
        wr_en && widx == irqdc_pkg::IDX_DMA_SOFT_REQUEST && w_data_r[0];
    endsequence
    sequence dma_burst_select_wr_s;
        wr_en && widx == irqdc_pkg::IDX_DMA_BURST_SELECT;
    endsequence
    flag_set_a: assert property (src_evt[1] |=> flag_r[1])
        else $error("event did not set its flag");
    clr_vec_a: assert property (wr_en && widx == irqdc_pkg::IDX_CLR
            && w_data_r[5:0] == vec_of(1) && !src_evt[1] |=> !flag_r[1])
        else $error("clear vector left flag set");
    soft_req_a: assert property (dma_soft_request_wr_s |=> soft_r[0] ##1 dma_r.req[0])
        else $error("software DMA request not raised");
    burst_sel_a: assert property (dma_burst_select_wr_s ##1 1'b1 |=> dma_r.burst == $past(burst_r))
        else $error("burst select not forwarded");
    lvl_mode_a: assert property (le_r[0] && ext_in[0] |=> flag_r[0])
        else $error("level input did not set flag");
    fall_edge_a: assert property (!le_r[0] && pol_r[0] && ext_prev_r[0] && !ext_in[0]
            |=> flag_r[0])
        else $error("falling edge missed");
    nmi_rise_a: assert property (!nmi_prev_r && nmi_in |=> nmi_out == nrise_r)
        else $error("rising edge handling wrong");
    ovf_sep_a: assert property (src_evt[16] && !src_evt[14] && !flag_r[14]
            |=> flag_r[16] && !flag_r[14])
        else $error("overflow source not separate");
    lvl_zero_a: assert property (cpu_req.valid |-> cpu_req.level != 3'h0)
        else $error("level zero source offered");
endmodule : irqdc_top

/* File: hdl/irqdc_pkg.sv */
// Purpose: Shared constants and carriers of the interrupt and DMA request bank
// Assumes: Register index times four is the AXI byte address
// Notes:   Sources are numbered by nibble position over the control registers
package irqdc_pkg;
    // Sizes
    localparam int NSLOT = 12;                   // Control registers
    localparam int NSRC  = 24;                   // Nibble slots, two per register
    localparam int NEXT  = 6;                    // External request inputs
    localparam int NDMA  = 4;                    // DMA channels
    localparam int NST   = 3;                    // Sticky status events
    // Register indices
    localparam logic [7:0] IDX_DMAV0   = 8'h80;
    localparam logic [7:0] IDX_DMAV3   = 8'h83;
    localparam logic [7:0] IDX_CLR     = 8'h88;
    localparam logic [7:0] IDX_DMA_SOFT_REQUEST    = 8'h89;
    localparam logic [7:0] IDX_DMA_BURST_SELECT    = 8'h8A;
    localparam logic [7:0] IDX_MODE_LO = 8'h8C;
    localparam logic [7:0] IDX_MODE_HI = 8'h8D;
    localparam logic [7:0] IDX_STAT    = 8'hA8;
    localparam logic [7:0] IDX_MASK    = 8'hA9;
    localparam logic [7:0] CTL_IDX [NSLOT] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h95, 8'h96,
                                              8'h97, 8'h99, 8'h9B, 8'h9C, 8'hA0, 8'hA1};
    // Slots with a real source behind them
    localparam logic [NSRC-1:0] SRC_USED = 24'hFDFF7F;
    // Nibble of each external input, and of timer overflow
    localparam int EXT_NIB [NEXT] = '{0, 2, 3, 4, 5, 6};
    localparam int TB_OVF_NIB = 16;
    // Field positions
    localparam int VEC_W    = 6;
    localparam int LVL_W    = 3;
    localparam int FLAG_POS = 3;                 // Flag bit inside a nibble
    localparam int NMI_POS  = 0;                 // Rising-edge enable in low mode byte
    localparam int LE_POS   = 1;                 // Level select of input k at LE_POS+2k
    localparam int EDGE_POS = 2;                 // Polarity of input k at EDGE_POS+2k
    localparam int ST_NMI   = 0;                 // Non-maskable edge seen
    localparam int ST_BADCLR = 1;                // Clear vector matched no source
    localparam int ST_SOFT  = 2;                 // Software DMA request written
    // Reset values and bus answers
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [1:0] RESP_OK    = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Request offered to the CPU
    typedef struct packed {
        logic             valid;
        logic [LVL_W-1:0] level;
        logic [VEC_W-1:0] vector;
    } irqdc_cpu_req_t;
    // Requests offered to the DMA engine
    typedef struct packed {
        logic [NDMA-1:0] req;
        logic [NDMA-1:0] burst;
    } irqdc_dma_t;
endpackage : irqdc_pkg

/* File: testbench/irqdc_host_model.sv */
// Purpose: Behavioural CPU and DMA engine facing the request bank
// Assumes: Acknowledges are one-cycle pulses, given only while enabled
// Notes:   Slow mode pauses longer between answers
`timescale 1ns/100ps
module irqdc_host_model (
    // Clock and bench control
    input  wire logic                      aclk,
    input  wire logic                      en,
    input  wire logic                      slow,
    // Requests in, acknowledges out
    input  wire irqdc_pkg::irqdc_cpu_req_t cpu_req,
    input  wire irqdc_pkg::irqdc_dma_t     dma,
    output logic                           cpu_ack = 1'b0,
    output logic [3:0]                     dma_ack = 4'h0
);
    int w = 0;                             // Cycles before next answer
    // Pause at least two cycles so a stale request is not taken twice
    always @(posedge aclk) begin
        cpu_ack <= 1'b0;
        dma_ack <= 4'h0;
        if (w > 0) begin
            w <= w - 1;
        end else if (en && (cpu_req.valid || dma.req != 4'h0)) begin
            cpu_ack <= cpu_req.valid;
            dma_ack <= dma.req;
            w       <= slow ? 6 : 2;
        end
    end
endmodule : irqdc_host_model

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench of the interrupt and DMA request bank
// Assumes: Byte address is register index times four
// Notes:   Bus answers are checked by a monitor against queued notes
`timescale 1ns/100ps
module testbench;
    localparam logic [5:0] VB = 6'h0A;     // Base vector, arbitrary
    // Bus and control
    logic        aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, arvalid = '0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        awready, wready, bvalid, arready, rvalid, nmi_out, irq, cpu_ack;
    logic [1:0]  bresp, rresp;
    logic [23:0] src_evt = '0;
    logic [5:0]  ext_in = '0;
    logic        nmi_in = '0, en = '0, slow = '0;
    logic [3:0]  dma_ack;
    irqdc_pkg::irqdc_cpu_req_t cpu_req;
    irqdc_pkg::irqdc_dma_t     dma;
    // Notes and tallies
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          fail_count = 0, checks_done = 0, nmi_cnt = 0, nb;
    logic [7:0]  d, fb, regs[7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h8A, 8'h8C, 8'h8D};
    irqdc_top #(.VEC_BASE(VB)) dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
        .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1),
        .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready(1'b1),
        .src_evt, .ext_in, .nmi_in, .cpu_req, .cpu_ack, .nmi_out, .dma, .dma_ack, .irq);
    irqdc_host_model host (.aclk, .en, .slow, .cpu_req, .dma, .cpu_ack, .dma_ack);
    always #25 aclk = ~aclk;
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task automatic chk(input string s, input logic [33:0] e, g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // Oldest note against each answer; non-maskable pulses tallied
    always @(posedge aclk) begin
        if (rvalid === 1'b1) chk("read", rq.pop_front(), {rresp, rdata});
        if (bvalid === 1'b1) chk("bresp", 34'(bq.pop_front()), 34'(bresp));
        if (nmi_out === 1'b1) nmi_cnt++;
    end
    // Bounded wait for a handshake sampled high at an edge
    task automatic await(ref logic s);
        int n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (s !== 1'b1 && n < 50);
        if (s !== 1'b1) begin
            fail_count++;
            conclude();
        end
    endtask : await
    task automatic wr(input logic [7:0] i, v, input logic [1:0] e = 2'h0);
        bit a, w;
        bq.push_back(e);
        awaddr  <= {2'h0, i, 2'h0};
        wdata   <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        // Address and data are released separately as each is taken
        for (int n = 0; n < 50 && !(a && w); n++) begin
            @(posedge aclk);
            if (awready === 1'b1) a = 1'b1;
            if (wready === 1'b1) w = 1'b1;
            awvalid <= !a;
            wvalid  <= !w;
        end
        await(bvalid);
    endtask : wr
    task automatic rd(input logic [7:0] i, v, input logic [1:0] e = 2'h0);
        rq.push_back({e, 24'h0, v});
        araddr  <= {2'h0, i, 2'h0};
        arvalid <= 1'b1;
        await(arready);
        arvalid <= 1'b0;
        await(rvalid);
    endtask : rd
    task automatic ev(input logic [23:0] b);
        src_evt <= b;
        @(posedge aclk);
        src_evt <= '0;
        repeat (3) @(posedge aclk);
    endtask : ev
    initial begin
        void'($urandom(32'h9EC9982D));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        // Control slots: zero reset, flag bits not writable, level fields are
        for (int i = 0; i < 12; i++) begin
            rd(irqdc_pkg::CTL_IDX[i], 8'h00);
            d = 8'($urandom);
            fb = 8'h77;
            wr(irqdc_pkg::CTL_IDX[i], d);
            rd(irqdc_pkg::CTL_IDX[i], d & fb);
            wr(irqdc_pkg::CTL_IDX[i], 8'h00);
        end
        // Vectors, burst and mode registers; mode reads back zero
        foreach (regs[i]) begin
            rd(regs[i], 8'h00);
            d = 8'($urandom) & 8'h7F;
            wr(regs[i], d);
            rd(regs[i], regs[i] > 8'h8B ? 8'h00 : d & (regs[i] < 8'h84 ? 8'h3F : 8'h0F));
            wr(regs[i], 8'h00);
        end
        rd(8'h84, 8'h00, 2'h2);
        wr(8'h8B, 8'h01, 2'h2);
        // Pending request offered with its level, cleared by vector
        wr(8'h90, 8'h50);
        ev(24'h000102);
        chk("cpu_req", 34'({1'b1, 3'h5, VB + 6'h01}), 34'(cpu_req));
        rd(8'h90, 8'hD0);
        rd(8'h95, 8'h08);
        wr(8'h88, {2'h0, VB + 6'h01});
        repeat (2) @(posedge aclk);
        rd(8'h90, 8'h50);
        chk("cpu_req valid", 34'h0, 34'(cpu_req.valid));
        wr(8'h88, {2'h0, VB + 6'h08});
        wr(8'h88, {2'h0, VB + 6'h07});
        // Timer overflow slot stands apart from the compare slots
        wr(8'h9B, 8'h03);
        ev(24'h010000);
        rd(8'h9B, 8'h0B);
        rd(8'h99, 8'h00);
        chk("cpu_req", 34'({1'b1, 3'h3, VB + 6'h10}), 34'(cpu_req));
        en <= 1'b1;
        repeat (6) @(posedge aclk);
        rd(8'h9B, 8'h03);
        wr(8'h90, 8'h00);
        // Each input in one mode; rising, falling and level taken in turn
        for (int k = 0; k < 6; k++) begin
            nb = irqdc_pkg::EXT_NIB[k];
            fb = (nb % 2) ? 8'h80 : 8'h08;
            d = 8'({k % 3 == 1, k % 3 == 2}) << (1 + 2 * (k % 3));
            wr(8'h8C, k < 3 ? d : 8'h00);
            wr(8'h8D, k < 3 ? 8'h00 : d);
            ext_in[k] <= 1'b1;
            repeat (3) @(posedge aclk);
            rd(irqdc_pkg::CTL_IDX[nb/2], k % 3 == 1 ? 8'h00 : fb);
            ext_in[k] <= 1'b0;
            repeat (3) @(posedge aclk);
            rd(irqdc_pkg::CTL_IDX[nb/2], fb);
            wr(8'h88, {2'h0, VB + 6'(nb)});
            rd(irqdc_pkg::CTL_IDX[nb/2], 8'h00);
        end
        // Falling edge always, rising only once enabled
        for (int j = 0; j < 4; j++) begin
            if (j == 2) wr(8'h8C, 8'h01);
            nmi_in <= ~nmi_in;
            repeat (4) @(posedge aclk);
            chk("nmi pulses", 34'(j), 34'(nmi_cnt));
        end
        // Software request raised, then answered by a slow engine
        en <= 1'b0;
        wr(8'h8A, 8'h09);
        wr(8'h89, 8'h05);
        repeat (2) @(posedge aclk);
        chk("burst", 34'h9, 34'(dma.burst));
        chk("dma req", 34'h5, 34'(dma.req));
        rd(8'h89, 8'h05);
        slow <= 1'b1;
        en <= 1'b1;
        repeat (5) @(posedge aclk);
        chk("dma req", 34'h0, 34'(dma.req));
        rd(8'h89, 8'h00);
        // Sticky status, mask and one-to-clear
        rd(8'hA8, 8'h07);
        chk("irq", 34'h0, 34'(irq));
        wr(8'hA9, 8'h02);
        repeat (2) @(posedge aclk);
        chk("irq", 34'h1, 34'(irq));
        wr(8'hA8, 8'h02);
        repeat (2) @(posedge aclk);
        chk("irq", 34'h0, 34'(irq));
        rd(8'hA8, 8'h05);
        repeat (4) @(posedge aclk);
        if (rq.size() + bq.size() != 0) fail_count++;
        conclude();
    end
endmodule : testbench
